// ==== core/real_time_calendar_control.sv ====
// rtc control register block with ahb-lite slave, value registers and interrupts
module real_time_calendar_control
  import real_time_calendar_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic por_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic write_unlock,
  input wire logic secondary_oscillator_clk,
  input wire logic low_power_internal_oscillator_clk,
  output logic clock_output,
  output logic clock_output_oe,
  output logic interrupt
);
  // ********************
  // pin synchronisers
  // ********************
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] next_sync1;
  logic por_s1;
  logic por_s2;
  always_comb begin
    next_sync1 = {write_unlock, secondary_oscillator_clk, low_power_internal_oscillator_clk};
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
    end else begin
      sync1 <= next_sync1;
      sync2 <= sync1;
    end
  end
  // por_n is a pin too; only this synchroniser and the control register answer to it
  always_ff @(posedge hclk or negedge por_n) begin
    if (!por_n) begin
      por_s1 <= 1'b0;
      por_s2 <= 1'b0;
    end else begin
      por_s1 <= 1'b1;
      por_s2 <= por_s1;
    end
  end
  wire logic unlock_s = sync2[2];

  // ********************
  // timekeeping clock edge detect
  // ********************
  logic src_prev;
  logic next_src_prev;
  logic src_rise;
  logic [3:0] idle_cnt;
  logic [3:0] next_idle_cnt;
  logic running;
  logic next_running;
  real_time_calendar_ctrl_type ctrl;
  real_time_calendar_ctrl_type next_ctrl;
  logic src_level;
  always_comb begin
    if (ctrl.clock_source_select == REAL_TIME_CALENDAR_CLKSEL_SECONDARY) begin
      src_level = sync2[1];
    end else if (ctrl.clock_source_select == REAL_TIME_CALENDAR_CLKSEL_INTERNAL) begin
      src_level = sync2[0];
    end else begin
      src_level = 1'b0;
    end
    next_src_prev = src_level;
    src_rise = src_level && !src_prev && ctrl.on;
    next_idle_cnt = src_rise ? 4'h0 : (idle_cnt == REAL_TIME_CALENDAR_IDLE_LIMIT ? idle_cnt : idle_cnt + 4'h1);
    next_running = ctrl.on && (src_rise || (running && idle_cnt != REAL_TIME_CALENDAR_IDLE_LIMIT));
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src_prev <= 1'b0;
      idle_cnt <= REAL_TIME_CALENDAR_IDLE_LIMIT;
      running <= 1'b0;
    end else begin
      src_prev <= next_src_prev;
      idle_cnt <= next_idle_cnt;
      running <= next_running;
    end
  end

  // ********************
  // ahb-lite slave
  // ********************
  logic dp_write;
  logic dp_read;
  logic [7:0] dp_addr;
  logic next_dp_write;
  logic next_dp_read;
  logic [7:0] next_dp_addr;
  logic [31:0] next_hrdata;
  always_comb begin
    next_dp_write = hsel && hready && htrans[1] && hwrite;
    next_dp_read = hsel && hready && htrans[1] && !hwrite;
    next_dp_addr = haddr[7:0];
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write <= 1'b0;
      dp_read <= 1'b0;
      dp_addr <= 8'h00;
    end else begin
      dp_write <= next_dp_write;
      dp_read <= next_dp_read;
      dp_addr <= next_dp_addr;
    end
  end
  function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
    hit = (a == reg_addr);
  endfunction : hit

  // ********************
  // prescaler, value registers, flags
  // ********************
  logic [14:0] presc;
  logic [14:0] next_presc;
  real_time_calendar_values_type vals;
  real_time_calendar_values_type next_vals;
  logic [1:0] ripple;
  logic [1:0] next_ripple;
  logic sec_tick;
  logic half_sec;
  logic [1:0] irq_status;
  logic [1:0] next_irq_status;
  logic [1:0] irq_enable;
  logic [1:0] next_irq_enable;
  logic alarm_pulse;
  logic next_alarm_pulse;
  logic sec_wr;
  always_comb begin
    next_vals = vals;
    next_presc = presc + (src_rise ? 15'h0001 : 15'h0000);
    sec_tick = src_rise && presc == REAL_TIME_CALENDAR_PRESC_LAST;
    // time and date writes locked unless write enable set; alarm writes are not
    sec_wr = dp_write && ctrl.value_write_enable && hit(dp_addr, REAL_TIME_CALENDAR_TIME_ADDR);
    if (sec_tick) begin
      next_vals.time_value = vals.time_value + REAL_TIME_CALENDAR_SEC_STEP;
    end
    if (sec_wr) begin
      next_vals.time_value = hwdata;
      // seconds write restarts the half-second phase
      next_presc = 15'h0000;
    end
    if (dp_write && ctrl.value_write_enable && hit(dp_addr, REAL_TIME_CALENDAR_DATE_ADDR)) begin
      next_vals.date_value = hwdata;
    end
    if (dp_write && hit(dp_addr, REAL_TIME_CALENDAR_ALARM_ADDR)) begin
      next_vals.alarm_value = hwdata;
    end
    // sync window opens ahead of a rollover
    next_ripple = (ripple != 2'h0) ? ripple - 2'h1 : 2'h0;
    if (src_rise && presc >= REAL_TIME_CALENDAR_PRESC_LAST - 15'h0001) begin
      next_ripple = 2'h3;
    end
    next_alarm_pulse = sec_tick && (next_vals.time_value == vals.alarm_value);
    next_irq_status = irq_status;
    if (dp_write && hit(dp_addr, REAL_TIME_CALENDAR_IRQ_CLEAR_ADDR)) begin
      next_irq_status = irq_status & ~hwdata[1:0];
    end
    // set wins over clear
    next_irq_status[REAL_TIME_CALENDAR_IRQ_ALARM_BIT] = next_irq_status[REAL_TIME_CALENDAR_IRQ_ALARM_BIT] | next_alarm_pulse;
    next_irq_status[REAL_TIME_CALENDAR_IRQ_SECOND_BIT] = next_irq_status[REAL_TIME_CALENDAR_IRQ_SECOND_BIT] | sec_tick;
    next_irq_enable = irq_enable;
    if (dp_write && hit(dp_addr, REAL_TIME_CALENDAR_IRQ_ENABLE_ADDR)) begin
      next_irq_enable = hwdata[1:0];
    end
  end
  // upper prescaler bit marks the second half of a second
  assign half_sec = presc[14];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      presc <= 15'h0000;
      vals <= '0;
      ripple <= 2'h0;
      alarm_pulse <= 1'b0;
      irq_status <= 2'h0;
      irq_enable <= 2'h0;
    end else begin
      presc <= next_presc;
      vals <= next_vals;
      ripple <= next_ripple;
      alarm_pulse <= next_alarm_pulse;
      irq_status <= next_irq_status;
      irq_enable <= next_irq_enable;
    end
  end

  // ********************
  // control register, power-on reset only
  // ********************
  always_comb begin
    next_ctrl = ctrl;
    // writes wait for the synchronised power-on release, so none lands mid-reset
    if (por_s2 && dp_write && hit(dp_addr, REAL_TIME_CALENDAR_CONTROL_ADDR)) begin
      next_ctrl.clock_source_select = hwdata[REAL_TIME_CALENDAR_CLKSEL_LSB +: 2];
      next_ctrl.output_signal_select = hwdata[REAL_TIME_CALENDAR_OUTSEL_LSB +: 2];
      next_ctrl.clock_output_enable = hwdata[REAL_TIME_CALENDAR_OE_BIT];
      // on bit guarded by write enable
      if (ctrl.value_write_enable) begin
        next_ctrl.on = hwdata[REAL_TIME_CALENDAR_ON_BIT];
      end
      // setting needs the unlock input; clearing always allowed
      if (!hwdata[REAL_TIME_CALENDAR_WREN_BIT] || unlock_s) begin
        next_ctrl.value_write_enable = hwdata[REAL_TIME_CALENDAR_WREN_BIT];
      end
    end
  end
  // system reset leaves the control register alone
  always_ff @(posedge hclk or negedge por_n) begin
    if (!por_n) begin
      ctrl <= '0;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // ********************
  // read mux, pin and interrupt outputs
  // ********************
  logic next_clock_output;
  logic next_clock_output_oe;
  always_comb begin
    next_hrdata = REAL_TIME_CALENDAR_ZERO_RESET;
    if (next_dp_read && hit(next_dp_addr, REAL_TIME_CALENDAR_CONTROL_ADDR)) begin
      next_hrdata[REAL_TIME_CALENDAR_ON_BIT] = ctrl.on;
      next_hrdata[REAL_TIME_CALENDAR_CLKSEL_LSB +: 2] = ctrl.clock_source_select;
      next_hrdata[REAL_TIME_CALENDAR_OUTSEL_LSB +: 2] = ctrl.output_signal_select;
      next_hrdata[REAL_TIME_CALENDAR_RUNNING_BIT] = running;
      next_hrdata[REAL_TIME_CALENDAR_WREN_BIT] = ctrl.value_write_enable;
      next_hrdata[REAL_TIME_CALENDAR_SYNC_BIT] = ripple != 2'h0;
      next_hrdata[REAL_TIME_CALENDAR_HALF_SECOND_BIT] = half_sec;
      next_hrdata[REAL_TIME_CALENDAR_OE_BIT] = ctrl.clock_output_enable;
    end else if (next_dp_read && hit(next_dp_addr, REAL_TIME_CALENDAR_TIME_ADDR)) begin
      next_hrdata = vals.time_value;
    end else if (next_dp_read && hit(next_dp_addr, REAL_TIME_CALENDAR_DATE_ADDR)) begin
      next_hrdata = vals.date_value;
    end else if (next_dp_read && hit(next_dp_addr, REAL_TIME_CALENDAR_IRQ_STATUS_ADDR)) begin
      next_hrdata[1:0] = irq_status;
    end else if (next_dp_read && hit(next_dp_addr, REAL_TIME_CALENDAR_IRQ_ENABLE_ADDR)) begin
      next_hrdata[1:0] = irq_enable;
    end else if (next_dp_read && hit(next_dp_addr, REAL_TIME_CALENDAR_ALARM_ADDR)) begin
      next_hrdata = vals.alarm_value;
    end
    case (ctrl.output_signal_select)
      REAL_TIME_CALENDAR_OUT_CLOCK: next_clock_output = src_level;
      REAL_TIME_CALENDAR_OUT_SECONDS: next_clock_output = half_sec;
      REAL_TIME_CALENDAR_OUT_ALARM: next_clock_output = alarm_pulse;
      default: next_clock_output = 1'b0;
    endcase
    // pin driven only when output enable set
    next_clock_output_oe = ctrl.clock_output_enable;
    if (!ctrl.clock_output_enable) begin
      next_clock_output = 1'b0;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= REAL_TIME_CALENDAR_ZERO_RESET;
      clock_output <= 1'b0;
      clock_output_oe <= 1'b0;
      interrupt <= 1'b0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hrdata <= next_hrdata;
      clock_output <= next_clock_output;
      clock_output_oe <= next_clock_output_oe;
      interrupt <= |(next_irq_status & next_irq_enable);
      // zero-wait okay-only slave, kept in flops like every other output
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
endmodule : real_time_calendar_control

// ==== core/real_time_calendar_pkg.sv ====
// package: register map, field layout, reset values and types of the rtc control block
package real_time_calendar_pkg;
  // ********************
  // register map (byte addresses)
  // ********************
  localparam logic [7:0] REAL_TIME_CALENDAR_CONTROL_ADDR = 8'h00;
  localparam logic [7:0] REAL_TIME_CALENDAR_TIME_ADDR = 8'h04;
  localparam logic [7:0] REAL_TIME_CALENDAR_DATE_ADDR = 8'h08;
  localparam logic [7:0] REAL_TIME_CALENDAR_IRQ_STATUS_ADDR = 8'h0c;
  localparam logic [7:0] REAL_TIME_CALENDAR_IRQ_ENABLE_ADDR = 8'h10;
  localparam logic [7:0] REAL_TIME_CALENDAR_IRQ_CLEAR_ADDR = 8'h14;
  localparam logic [7:0] REAL_TIME_CALENDAR_ALARM_ADDR = 8'h18;

  // ********************
  // control register fields
  // ********************
  localparam int REAL_TIME_CALENDAR_ON_BIT = 15;
  localparam int REAL_TIME_CALENDAR_CLKSEL_LSB = 9;
  localparam int REAL_TIME_CALENDAR_OUTSEL_LSB = 7;
  localparam int REAL_TIME_CALENDAR_RUNNING_BIT = 6;
  localparam int REAL_TIME_CALENDAR_WREN_BIT = 3;
  localparam int REAL_TIME_CALENDAR_SYNC_BIT = 2;
  localparam int REAL_TIME_CALENDAR_HALF_SECOND_BIT = 1;
  localparam int REAL_TIME_CALENDAR_OE_BIT = 0;
  localparam int REAL_TIME_CALENDAR_SEC_LSB = 8;
  localparam int REAL_TIME_CALENDAR_SEC_MSB = 14;

  localparam logic [1:0] REAL_TIME_CALENDAR_CLKSEL_INTERNAL = 2'h0;
  localparam logic [1:0] REAL_TIME_CALENDAR_CLKSEL_SECONDARY = 2'h1;
  localparam logic [1:0] REAL_TIME_CALENDAR_OUT_ALARM = 2'h0;
  localparam logic [1:0] REAL_TIME_CALENDAR_OUT_SECONDS = 2'h1;
  localparam logic [1:0] REAL_TIME_CALENDAR_OUT_CLOCK = 2'h2;

  // ********************
  // reset values and interrupt layout
  // ********************
  localparam logic [31:0] REAL_TIME_CALENDAR_ZERO_RESET = 32'h0000_0000;
  localparam int REAL_TIME_CALENDAR_IRQ_ALARM_BIT = 0;
  localparam int REAL_TIME_CALENDAR_IRQ_SECOND_BIT = 1;
  localparam int REAL_TIME_CALENDAR_SYNC_WINDOW = 2;
  localparam logic [14:0] REAL_TIME_CALENDAR_PRESC_LAST = 15'h7fff;
  localparam logic [3:0] REAL_TIME_CALENDAR_IDLE_LIMIT = 4'hf;
  localparam logic [31:0] REAL_TIME_CALENDAR_SEC_STEP = 32'h0000_0100;

  typedef struct packed {
    logic on;
    logic [1:0] clock_source_select;
    logic [1:0] output_signal_select;
    logic value_write_enable;
    logic clock_output_enable;
  } real_time_calendar_ctrl_type;

  typedef struct packed {
    logic [31:0] time_value;
    logic [31:0] date_value;
    logic [31:0] alarm_value;
  } real_time_calendar_values_type;
endpackage : real_time_calendar_pkg

// ==== sim/real_time_calendar_control_properties.sv ====
// checker: port-level properties of the rtc control block
module real_time_calendar_control_properties
  import real_time_calendar_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic por_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic clock_output,
  input wire logic clock_output_oe,
  input wire logic interrupt
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********************
  // bus history and properties
  // ********************
  logic rd_q;
  logic [7:0] a_q;
  logic [3:0] wr_h;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_q <= 1'b0;
      a_q <= 8'h00;
      wr_h <= 4'h0;
    end else begin
      rd_q <= hsel && hready && htrans[1] && !hwrite;
      a_q <= haddr[7:0];
      wr_h <= {wr_h[2:0], hsel && hready && htrans[1] && hwrite};
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_ready_zero_wait: assert property (hreadyout) else $error("ready low");
  a_resp_okay: assert property (!hresp) else $error("error response");
  a_rdata_idle: assert property (!rd_q |-> hrdata == 32'h0000_0000)
    else $error("read data outside data phase");
  a_unmapped_zero: assert property (rd_q && a_q > 8'h18 |-> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_ctrl_unused: assert property (rd_q && a_q == REAL_TIME_CALENDAR_CONTROL_ADDR |->
    hrdata[31:16] == 16'h0000 && hrdata[14:11] == 4'h0 && hrdata[5:4] == 2'h0)
    else $error("unused control bits set");
  a_out_gated: assert property (!clock_output_oe |-> !clock_output)
    else $error("output active while disabled");
  a_por_clears_oe: assert property (!por_n ##1 !por_n |-> !clock_output_oe)
    else $error("output enable kept through power-on reset");
  // interrupt only drops after a clear or mask write
  a_irq_fall_write: assert property ($fell(interrupt) |-> |wr_h)
    else $error("interrupt dropped without write");
  cover property (rd_q && a_q == REAL_TIME_CALENDAR_CONTROL_ADDR);
  cover property (interrupt);
  cover property ($rose(clock_output));
endmodule : real_time_calendar_control_properties

bind real_time_calendar_control real_time_calendar_control_properties u_real_time_calendar_control_properties (
  .hclk(hclk), .hresetn(hresetn), .por_n(por_n), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .clock_output(clock_output),
  .clock_output_oe(clock_output_oe), .interrupt(interrupt));

// ==== sim/real_time_calendar_control_tb.sv ====
// testbench: register-level scenarios for the rtc control block
module real_time_calendar_control_tb import real_time_calendar_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // ********************
  // stimulus, tasks and scenarios
  // ********************
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic por_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic write_unlock = 1'b0;
  logic sec_osc = 1'b0;
  logic int_osc = 1'b0;
  logic run_s = 1'b0;
  logic run_l = 1'b0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, clock_output, clock_output_oe, interrupt;
  int error_cnt = 0;
  int cmp_count = 0;
  int n;
  int pulses = 0;
  int base = 0;
  logic [31:0] rd;
  always #5 hclk = ~hclk;
  // slow sources toggle at half the bus rate so the run stays short
  always @(posedge hclk) begin
    if (run_s) sec_osc <= ~sec_osc;
    if (run_l) int_osc <= ~int_osc;
  end
  // counts every high cycle of the pin; the alarm check uses a difference
  always @(posedge hclk) begin
    if (clock_output === 1'b1) begin
      pulses <= pulses + 1;
    end
  end
  real_time_calendar_control u_real_time_calendar_control (.hclk(hclk), .hresetn(hresetn), .por_n(por_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .write_unlock(write_unlock), .secondary_oscillator_clk(sec_osc),
    .low_power_internal_oscillator_clk(int_osc), .clock_output(clock_output),
    .clock_output_oe(clock_output_oe), .interrupt(interrupt));
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wait_ready();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (hreadyout !== 1'b1) begin
      error_cnt++;
      conclude();
    end
  endtask : wait_ready
  // data-phase outputs are read at the edge, before its own updates land
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask : xfer
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    xfer(1'b0, a, 32'h0000_0000);
    chk(what, exp, rd);
  endtask : rchk
  task automatic highs(input int cyc);
    n = 0;
    repeat (cyc) begin
      @(posedge hclk);
      if (clock_output === 1'b1) n++;
    end
  endtask : highs
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    por_n <= 1'b1;
    repeat (3) @(posedge hclk);
    rchk(REAL_TIME_CALENDAR_CONTROL_ADDR, 32'h0000_0000, "control");
    rchk(8'h1c, 32'h0000_0000, "unmapped");
    xfer(1'b1, REAL_TIME_CALENDAR_CONTROL_ADDR, 32'h0000_8289);
    rchk(REAL_TIME_CALENDAR_CONTROL_ADDR, 32'h0000_0281, "locked control");
    xfer(1'b1, REAL_TIME_CALENDAR_TIME_ADDR, 32'h0000_0500);
    rchk(REAL_TIME_CALENDAR_TIME_ADDR, 32'h0000_0000, "locked time");
    write_unlock <= 1'b1;
    repeat (3) @(posedge hclk);
    xfer(1'b1, REAL_TIME_CALENDAR_CONTROL_ADDR, 32'h0000_0289);
    xfer(1'b1, REAL_TIME_CALENDAR_CONTROL_ADDR, 32'h0000_8289);
    highs(20);
    rchk(REAL_TIME_CALENDAR_CONTROL_ADDR, 32'h0000_8289, "stopped source");
    run_s <= 1'b1;
    highs(20);
    rchk(REAL_TIME_CALENDAR_CONTROL_ADDR, 32'h0000_82c9, "running source");
    run_s <= 1'b0;
    run_l <= 1'b1;
    highs(20);
    rchk(REAL_TIME_CALENDAR_CONTROL_ADDR, 32'h0000_8289, "other source");
    xfer(1'b1, REAL_TIME_CALENDAR_CONTROL_ADDR, 32'h0000_8108);
    xfer(1'b1, REAL_TIME_CALENDAR_TIME_ADDR, 32'h0000_0000);
    highs(20);
    chk("output off", 32'h0000_0000, n);
    chk("output enable off", 32'h0000_0000, {31'h0, clock_output_oe});
    xfer(1'b1, REAL_TIME_CALENDAR_CONTROL_ADDR, 32'h0000_8109);
    highs(20);
    chk("clock output", 32'h0000_0001, 32'(n > 3));
    chk("output enable on", 32'h0000_0001, {31'h0, clock_output_oe});
    xfer(1'b1, REAL_TIME_CALENDAR_CONTROL_ADDR, 32'h0000_8089);
    xfer(1'b1, REAL_TIME_CALENDAR_TIME_ADDR, 32'h0000_0500);
    rchk(REAL_TIME_CALENDAR_TIME_ADDR, 32'h0000_0500, "time");
    rchk(REAL_TIME_CALENDAR_CONTROL_ADDR, 32'h0000_80c9, "first half");
    xfer(1'b1, REAL_TIME_CALENDAR_ALARM_ADDR, 32'h0000_0600);
    xfer(1'b1, REAL_TIME_CALENDAR_IRQ_ENABLE_ADDR, 32'h0000_0003);
    repeat (32800) @(posedge hclk);
    rchk(REAL_TIME_CALENDAR_CONTROL_ADDR, 32'h0000_80cb, "second half");
    chk("seconds output", 32'h0000_0001, {31'h0, clock_output});
    xfer(1'b1, REAL_TIME_CALENDAR_TIME_ADDR, 32'h0000_0500);
    rchk(REAL_TIME_CALENDAR_CONTROL_ADDR, 32'h0000_80c9, "half cleared");
    xfer(1'b1, REAL_TIME_CALENDAR_CONTROL_ADDR, 32'h0000_8009);
    repeat (2) @(posedge hclk);
    base = pulses;
    // poll across the rollover; a read every two cycles cannot miss the sync window
    n = 0;
    rd = 32'h0000_0000;
    while (rd[REAL_TIME_CALENDAR_SYNC_BIT] !== 1'b1 && n < 40000) begin
      xfer(1'b0, REAL_TIME_CALENDAR_CONTROL_ADDR, 32'h0000_0000);
      n++;
    end
    chk("sync seen", 32'h0000_0001, {31'h0, rd[REAL_TIME_CALENDAR_SYNC_BIT]});
    if (rd[REAL_TIME_CALENDAR_SYNC_BIT] !== 1'b1) begin
      conclude();
    end
    repeat (10) @(posedge hclk);
    chk("alarm pulse", 32'h0000_0001, 32'(pulses - base));
    rchk(REAL_TIME_CALENDAR_TIME_ADDR, 32'h0000_0600, "tick time");
    rchk(REAL_TIME_CALENDAR_TIME_ADDR, 32'h0000_0600, "tick time again");
    rchk(REAL_TIME_CALENDAR_IRQ_STATUS_ADDR, 32'h0000_0003, "irq status");
    chk("irq raised", 32'h0000_0001, {31'h0, interrupt});
    xfer(1'b1, REAL_TIME_CALENDAR_IRQ_ENABLE_ADDR, 32'h0000_0000);
    repeat (3) @(posedge hclk);
    chk("irq masked", 32'h0000_0000, {31'h0, interrupt});
    xfer(1'b1, REAL_TIME_CALENDAR_IRQ_CLEAR_ADDR, 32'h0000_0003);
    rchk(REAL_TIME_CALENDAR_IRQ_STATUS_ADDR, 32'h0000_0000, "irq cleared");
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    xfer(1'b0, REAL_TIME_CALENDAR_CONTROL_ADDR, 32'h0000_0000);
    chk("kept control", 32'h0000_8009, rd & 32'hffff_ffb9);
    por_n <= 1'b0;
    repeat (3) @(posedge hclk);
    por_n <= 1'b1;
    repeat (3) @(posedge hclk);
    rchk(REAL_TIME_CALENDAR_CONTROL_ADDR, 32'h0000_0000, "power-on control");
    conclude();
  end
endmodule : real_time_calendar_control_tb
